// ---- bench/orf_checker_sva.sv ----
// port assertions for the overload range flag block
`timescale 1ns/1ps
`default_nettype none
`include "orf_consts.svh"
module orf_checker (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic range_cmp_i,
  input wire logic conv_start_i,
  input wire logic read_done_i,
  input wire logic conv_valid_i,
  input wire logic [`ORF_WORD_W-1:0] conv_word_i,
  input wire logic [`ORF_CSUM_W-1:0] checksum_i,
  input wire logic flag_in_checksum_i,
  input wire logic bits_valid_o,
  input wire logic data_valid_o,
  input wire logic [`ORF_WORD_W-1:0] data_word_o,
  input wire logic [`ORF_CSUM_W-1:0] checksum_o,
  input wire logic out_of_range_o,
  input wire logic recovering_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // eight quiet cycles cover the comparator synchroniser delay with margin
  sequence s_quiet;
    !range_cmp_i [*8];
  endsequence
  sequence s_clear;
    s_quiet ##0 (read_done_i || conv_start_i);
  endsequence
  a_tick_period: assert property (bits_valid_o |=> !bits_valid_o [*7] ##1 bits_valid_o)
    else $error("tick spacing wrong");
  a_stamp_pulse: assert property (data_valid_o == $past(conv_valid_i))
    else $error("result pulse wrong");
  a_flag_lsb: assert property (conv_valid_i && !flag_in_checksum_i |=>
    data_word_o[`ORF_WORD_W-1:1] == $past(conv_word_i[`ORF_WORD_W-1:1]) &&
    checksum_o == $past(checksum_i) && (data_word_o[0] || !$past(out_of_range_o)))
    else $error("word flag wrong");
  a_flag_csum: assert property (conv_valid_i && flag_in_checksum_i |=>
    data_word_o == $past(conv_word_i) &&
    checksum_o[`ORF_CSUM_FLAG_BIT-1:0] == $past(checksum_i[`ORF_CSUM_FLAG_BIT-1:0]) &&
    (checksum_o[`ORF_CSUM_FLAG_BIT] || !$past(out_of_range_o)))
    else $error("checksum flag wrong");
  a_flag_hold: assert property (out_of_range_o && !read_done_i && !conv_start_i |=>
    out_of_range_o) else $error("flag dropped");
  a_flag_set: assert property (range_cmp_i [*8] |-> out_of_range_o)
    else $error("flag not set");
  a_flag_clear: assert property (s_clear |=> !out_of_range_o)
    else $error("flag not cleared");
  a_recover_bound: assert property ($rose(recovering_o) |-> ##[1:97] !recovering_o)
    else $error("recovery too long");
endmodule // orf_checker
bind orf_overload_range_flag orf_checker u_chk (.clock_i, .sys_rst_i, .range_cmp_i,
  .conv_start_i, .read_done_i, .conv_valid_i, .conv_word_i, .checksum_i,
  .flag_in_checksum_i, .bits_valid_o, .data_valid_o, .data_word_o, .checksum_o,
  .out_of_range_o, .recovering_o);
`default_nettype wire

// ---- bench/orf_filter_model.sv ----
// far-side filter model: one result per request, junk on the lines otherwise
`timescale 1ns/1ps
`default_nettype none
`include "orf_consts.svh"
module orf_filter_model (
  input wire logic clock_i,
  input wire logic go_i,
  input wire logic [`ORF_WORD_W-1:0] word_i,
  input wire logic [`ORF_CSUM_W-1:0] csum_i,
  output logic conv_valid_o,
  output logic [`ORF_WORD_W-1:0] conv_word_o,
  output logic [`ORF_CSUM_W-1:0] checksum_o
);
  // inverted data outside the valid cycle catches a block that samples late
  always_ff @(posedge clock_i) begin
    conv_valid_o <= go_i;
    conv_word_o <= go_i ? word_i : ~word_i;
    checksum_o <= go_i ? csum_i : ~csum_i;
  end
endmodule // orf_filter_model
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the overload range flag block
`timescale 1ns/1ps
`default_nettype none
`include "orf_consts.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED at %0t: value mismatch", $time); end end
module tb;
  import orf_pkg::*;
  logic clock_i, sys_rst_i = 1, s1 = 0, s2 = 0, cmp = 0, start = 0, rd = 0, fic = 0, dbl = 0;
  logic go = 0, cv, bv, b1, b2, dv, oor, od, sat, rec, set, mc;
  logic [`ORF_WORD_W-1:0] word = '0, cw, dw;
  logic [`ORF_CSUM_W-1:0] csum = '0, cc, dc;
  orf_mode_e mode;
  int fails = 0, cmp_count = 0, cycles = 0;
  orf_filter_model u_filt (.clock_i(clock_i), .go_i(go), .word_i(word), .csum_i(csum),
    .conv_valid_o(cv), .conv_word_o(cw), .checksum_o(cc));
  orf_overload_range_flag u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .stage1_bit_i(s1),
    .stage2_bit_i(s2), .range_cmp_i(cmp), .conv_start_i(start), .read_done_i(rd),
    .conv_valid_i(cv), .conv_word_i(cw), .checksum_i(cc), .flag_in_checksum_i(fic),
    .avg_double_i(dbl), .mod_clk_o(mc), .bits_valid_o(bv), .stage1_bit_o(b1),
    .stage2_bit_o(b2), .data_valid_o(dv), .data_word_o(dw), .checksum_o(dc),
    .out_of_range_o(oor), .overdrive_o(od), .saturated_o(sat), .recovering_o(rec),
    .settled_o(set), .mode_o(mode));
  initial begin
    clock_i = 0;
    forever #4 clock_i = ~clock_i;
  end
  task automatic end_sim();
    $display("%0d comparisons, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // a hang counts as a mismatch; the tests need well under 6000 cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic tick(input logic b, input int n);
    s1 = b;
    cyc(8 * n);
  endtask
  task automatic result(input logic [23:0] w, input logic [7:0] c);
    word = w;
    csum = c;
    go = 1;
    cyc(1);
    go = 0;
    cyc(1);
    `CHK(dv, 1'b1)
    cyc(1);
  endtask
  task automatic set_flag();
    cmp = 1;
    cyc(8);
    cmp = 0;
    cyc(8);
  endtask
  task automatic settle(input int n);
    for (int i = 1; i <= n; i++) begin
      result(24'h000100, 8'h00);
      `CHK(set, i == n)
    end
  endtask
  task automatic t_basic();
    `CHK({set, oor, sat, rec, od, dv}, 6'b100000)
    s1 = 1;
    cyc(16);
    `CHK({b1, b2}, 2'b10)
    `CHK({bv, mc}, 2'b10)
    s1 = 0;
    s2 = 1;
    cyc(16);
    `CHK({b1, b2}, 2'b01)
    $display("basic test ended");
  endtask
  task automatic t_flag();
    set_flag();
    `CHK(oor, 1'b1)
    result(24'hABCDE2, 8'h12);
    `CHK({dw, dc}, {24'hABCDE3, 8'h12})
    rd = 1;
    cyc(1);
    rd = 0;
    `CHK(oor, 1'b0)
    `CHK({bv, mc}, 2'b01)
    fic = 1;
    set_flag();
    result(24'h13579B, 8'h34);
    `CHK({dw, dc}, {24'h13579B, 8'hB4})
    start = 1;
    cyc(1);
    start = 0;
    `CHK(oor, 1'b0)
    fic = 0;
    result(24'h2468AD, 8'h81);
    `CHK({dw, dc}, {24'h2468AC, 8'h81})
    $display("flag test ended");
  endtask
  task automatic t_over();
    repeat (4) begin
      tick(1, 15);
      tick(0, 1);
    end
    `CHK({od, sat}, 2'b10)
    repeat (24) begin
      tick(1, 1);
      tick(0, 1);
    end
    `CHK({od, mode}, {1'b0, ORF_SETTLING})
    settle(2);
    $display("overdrive test ended");
  endtask
  task automatic t_sat();
    for (int d = 0; d < 2; d++) begin
      dbl = d[0];
      tick(1, 20);
      `CHK(sat, 1'b1)
      repeat (8) begin
        tick(0, 1);
        tick(1, 1);
      end
      `CHK(mode, ORF_SETTLING)
      settle(2 + d);
    end
    $display("saturation test ended");
  endtask
  initial begin
    cyc(20);
    sys_rst_i = 0;
    t_basic();
    t_flag();
    t_over();
    t_sat();
    end_sim();
  end
endmodule // tb
`default_nettype wire

// ---- core/orf_consts.svh ----
// constants for the overload, range and flag logic
`ifndef ORF_CONSTS_SVH
`define ORF_CONSTS_SVH

`define ORF_WORD_W 24
`define ORF_CSUM_W 8
`define ORF_CSUM_FLAG_BIT 7
`define ORF_DIV_W 3
`define ORF_DIV_LAST 3'h7
`define ORF_DIV_MSB 2
`define ORF_RUN_W 5
`define ORF_RUN_MAX 5'h1F
`define ORF_SAT_RUN 5'h10
`define ORF_WIN_W 5
`define ORF_WIN_LAST 5'h1F
`define ORF_ONES_W 6
`define ORF_ONES_HI 6'h1D
`define ORF_ONES_LO 6'h03
`define ORF_REC_W 4
`define ORF_REC_LAST 4'hB
`define ORF_SET_W 2
`define ORF_SET_SINC1 2'h2
`define ORF_SET_SINC2 2'h3

`endif

// ---- core/orf_overload_range_flag.sv ----
// modulator bitstream hand-off, overload tracking and out-of-range flag
// Summary of operation
// - both second-order stage bitstreams are passed to the filter side each modulator cycle
// - first-stage ones density is about 90% at +FS and 10% at -FS
// - density between 90% and 100% keeps the bitstream running, no self reset
// - all ones or all zeros is held as a stable saturated state
// - after saturation the modulator returns to linear within 12 modulator cycles
// - after saturation exit settled data needs two more conversions, more in sinc2
// - after long non-saturating overdrive, data settles on the second reading, the third in sinc2
// - comparator fires beyond plus or minus 105 percent of full scale
// - latched flag goes out as word LSB or checksum bit 7
// - flag latch clears on data read or on new conversion start
// - modulator runs at one eighth of the master clock
// - single-stage averaging settles within two conversions after a step
`timescale 1ns/1ps
`default_nettype none
`include "orf_consts.svh"
module orf_overload_range_flag (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic stage1_bit_i,
  input wire logic stage2_bit_i,
  input wire logic range_cmp_i,
  input wire logic conv_start_i,
  input wire logic read_done_i,
  input wire logic conv_valid_i,
  input wire logic [`ORF_WORD_W-1:0] conv_word_i,
  input wire logic [`ORF_CSUM_W-1:0] checksum_i,
  input wire logic flag_in_checksum_i,
  input wire logic avg_double_i,
  output logic mod_clk_o,
  output logic bits_valid_o,
  output logic stage1_bit_o,
  output logic stage2_bit_o,
  output logic data_valid_o,
  output logic [`ORF_WORD_W-1:0] data_word_o,
  output logic [`ORF_CSUM_W-1:0] checksum_o,
  output logic out_of_range_o,
  output logic overdrive_o,
  output logic saturated_o,
  output logic recovering_o,
  output logic settled_o,
  output var orf_pkg::orf_mode_e mode_o
);
  import orf_pkg::*;

  logic stage1_s, stage2_s, range_s;

  orf_sync3 u_sync_stage1 (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i(stage1_bit_i),
    .sync_o(stage1_s)
  );

  orf_sync3 u_sync_stage2 (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i(stage2_bit_i),
    .sync_o(stage2_s)
  );

  // comparator level already means |vin| above 1.05 vref
  orf_sync3 u_sync_range (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i(range_cmp_i),
    .sync_o(range_s)
  );

  // ---------------- modulator clock divider and bit hand-off
  logic [`ORF_DIV_W-1:0] div_q, div_d;
  logic tick;
  logic bits_valid_q, bits_valid_d;
  logic stage1_q, stage1_d;
  logic stage2_q, stage2_d;

  assign tick = (div_q == `ORF_DIV_LAST);

  always_comb begin
    div_d = div_q + 1'b1;
    bits_valid_d = tick;
    stage1_d = stage1_q;
    stage2_d = stage2_q;
    if (tick) begin
      // one sample per modulator period, both stages together
      stage1_d = stage1_s;
      stage2_d = stage2_s;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      div_q <= '0;
      bits_valid_q <= 1'b0;
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      div_q <= div_d;
      bits_valid_q <= bits_valid_d;
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  // ---------------- density window and run length of the first stage
  logic [`ORF_RUN_W-1:0] run_q, run_d;
  logic [`ORF_WIN_W-1:0] win_q, win_d;
  logic [`ORF_ONES_W-1:0] ones_q, ones_d;
  logic over_q, over_d;
  logic block_end;
  logic [`ORF_ONES_W-1:0] ones_total;

  assign block_end = tick && (win_q == `ORF_WIN_LAST);
  assign ones_total = ones_q + {{(`ORF_ONES_W-1){1'b0}}, stage1_s};

  always_comb begin
    run_d = run_q;
    win_d = win_q;
    ones_d = ones_q;
    over_d = over_q;
    if (tick) begin
      // run length saturates so a long clamp never wraps back to linear
      if (stage1_s != stage1_q) begin
        run_d = {{(`ORF_RUN_W-1){1'b0}}, 1'b1};
      end else if (run_q != `ORF_RUN_MAX) begin
        run_d = run_q + 1'b1;
      end
      win_d = win_q + 1'b1;
      ones_d = ones_total;
      if (block_end) begin
        ones_d = '0;
        // beyond the +FS or -FS density counts as overdrive
        over_d = (ones_total >= `ORF_ONES_HI) || (ones_total <= `ORF_ONES_LO);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      run_q <= '0;
      win_q <= '0;
      ones_q <= '0;
      over_q <= 1'b0;
    end else begin
      run_q <= run_d;
      win_q <= win_d;
      ones_q <= ones_d;
      over_q <= over_d;
    end
  end

  // ---------------- overload state machine
  orf_mode_e mode_q, mode_d;
  logic [`ORF_REC_W-1:0] rec_q, rec_d;
  logic [`ORF_SET_W-1:0] set_q, set_d;
  logic [`ORF_SET_W-1:0] set_target;
  logic sat_now;
  logic saturated_q, saturated_d;
  logic recovering_q, recovering_d;
  logic settled_q, settled_d;

  assign sat_now = tick && (run_d >= `ORF_SAT_RUN);
  assign set_target = avg_double_i ? `ORF_SET_SINC2 : `ORF_SET_SINC1;

  always_comb begin
    mode_d = mode_q;
    rec_d = rec_q;
    set_d = set_q;
    case (mode_q)
      ORF_LINEAR: begin
        if (sat_now) begin
          mode_d = ORF_SATURATED;
        end else if (block_end && over_d) begin
          mode_d = ORF_OVERDRIVE;
        end
      end
      ORF_OVERDRIVE: begin
        // bitstream keeps flowing, nothing is reset here
        if (sat_now) begin
          mode_d = ORF_SATURATED;
        end else if (block_end && !over_d) begin
          mode_d = ORF_SETTLING;
          set_d = '0;
        end
      end
      ORF_SATURATED: begin
        // held until the first stage toggles again
        if (tick && (stage1_s != stage1_q)) begin
          mode_d = ORF_RECOVER;
          rec_d = '0;
        end
      end
      ORF_RECOVER: begin
        if (sat_now) begin
          mode_d = ORF_SATURATED;
        end else if (tick) begin
          if (rec_q == `ORF_REC_LAST) begin
            mode_d = ORF_SETTLING;
            set_d = '0;
          end else begin
            rec_d = rec_q + 1'b1;
          end
        end
      end
      ORF_SETTLING: begin
        if (sat_now) begin
          mode_d = ORF_SATURATED;
        end else if (conv_valid_i) begin
          if (set_q + 1'b1 == set_target) begin
            mode_d = ORF_LINEAR;
          end else begin
            set_d = set_q + 1'b1;
          end
        end
      end
      default: begin
        mode_d = ORF_LINEAR;
      end
    endcase
    // status pins copy the next state so they change on the same edge as mode_o
    saturated_d = (mode_d == ORF_SATURATED);
    recovering_d = (mode_d == ORF_RECOVER);
    settled_d = (mode_d == ORF_LINEAR);
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mode_q <= ORF_LINEAR;
      rec_q <= '0;
      set_q <= '0;
      saturated_q <= 1'b0;
      recovering_q <= 1'b0;
      settled_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      rec_q <= rec_d;
      set_q <= set_d;
      saturated_q <= saturated_d;
      recovering_q <= recovering_d;
      settled_q <= settled_d;
    end
  end

  // ---------------- out-of-range latch and result stamping
  logic flag_q, flag_d;
  logic data_valid_q, data_valid_d;
  logic [`ORF_WORD_W-1:0] word_q, word_d;
  logic [`ORF_CSUM_W-1:0] csum_q, csum_d;
  logic flag_now;

  // a trip in the same cycle as the stamp still reaches this result
  assign flag_now = flag_q | range_s;

  always_comb begin
    flag_d = flag_q;
    // set wins over clear so a trip in the clearing cycle is kept
    if (read_done_i || conv_start_i) begin
      flag_d = 1'b0;
    end
    if (range_s) begin
      flag_d = 1'b1;
    end
    data_valid_d = conv_valid_i;
    word_d = word_q;
    csum_d = csum_q;
    if (conv_valid_i) begin
      word_d = conv_word_i;
      csum_d = checksum_i;
      if (flag_in_checksum_i) begin
        csum_d[`ORF_CSUM_FLAG_BIT] = flag_now;
      end else begin
        // costs one bit of resolution in exchange for an inline flag
        word_d[0] = flag_now;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      flag_q <= 1'b0;
      data_valid_q <= 1'b0;
      word_q <= '0;
      csum_q <= '0;
    end else begin
      flag_q <= flag_d;
      data_valid_q <= data_valid_d;
      word_q <= word_d;
      csum_q <= csum_d;
    end
  end

  assign mod_clk_o = div_q[`ORF_DIV_MSB];
  assign bits_valid_o = bits_valid_q;
  assign stage1_bit_o = stage1_q;
  assign stage2_bit_o = stage2_q;
  assign data_valid_o = data_valid_q;
  assign data_word_o = word_q;
  assign checksum_o = csum_q;
  assign out_of_range_o = flag_q;
  assign overdrive_o = over_q;
  assign saturated_o = saturated_q;
  assign recovering_o = recovering_q;
  assign settled_o = settled_q;
  assign mode_o = mode_q;
endmodule // orf_overload_range_flag
`default_nettype wire

// ---- core/orf_pkg.sv ----
// types for the overload, range and flag logic
package orf_pkg;
  typedef enum logic [2:0] {
    ORF_LINEAR,
    ORF_OVERDRIVE,
    ORF_SATURATED,
    ORF_RECOVER,
    ORF_SETTLING
  } orf_mode_e;
endpackage

// ---- core/orf_sync3.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module orf_sync3 (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic s1_q, s2_q, s3_q, out_q;
  logic out_d;

  always_comb begin
    // first stage is only read by the second
    out_d = (s2_q == s3_q) ? s3_q : out_q;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_o = out_q;
endmodule // orf_sync3
`default_nettype wire
